// file: src/rtc_mfp_core.sv
// Purpose: Multi-function pin mux and digital trim of the 32.768 kHz timebase
// Assumes: osc_tick is a one-cycle enable at the oscillator rate
// Notes:   Alarm matching and square wave dividers live outside
//
// Behaviour
// (R1) Square wave off, an alarm on: pin is alarm interrupt.
// (R2) Alarm interrupt output keeps working on backup supply.
// (R3) One alarm on: pin equals flag if polarity 1, else inverse.
// (R4) Both alarms, polarity 1: pin is OR of flags.
// (R5) Both alarms, polarity 0: pin is NAND of flags.
// (R6) Square wave and alarms off: pin follows output-level bit.
// (R7) General purpose output unavailable on backup supply.
// (R8) Fine trim applied once per minute, automatically when magnitude nonzero.
// (R9) Sign 1 adds cycles, sign 0 removes cycles.
// (R10) Each magnitude step is two pulses, up to 254.
// (R11) Magnitude zero disables trimming regardless of sign.
// (R12) Coarse trim applies the adjustment 128 times per second; with sign 1 and magnitude 64 or more, every other point is skipped.
// (R13) Trimming continues on backup supply.
// (R14) Host calibrates by measuring frequency then loading trim.
// (R15) Host computes magnitude from frequency error scaled to per minute.
// (R16) Host clears sign when fast, sets it when slow.
// (R17) Host may calibrate by observing time drift instead.
// (R18) Square wave wins, then alarms, then general purpose output.
// (R19) Alarm flag set on match, sticky until cleared, resets if match persists.
// (R20) Coarse trim with square wave gives trimmed 64 Hz on pin.
// (R21) Trim at one fixed point per period, inserting or suppressing counts.
`timescale 1ns/100ps
`include "rtc_mfp_map.svh"
module rtc_mfp_core
    import rtc_mfp_pkg::*;
#(
    parameter int ADDR_W = 8
)
(
    input  wire logic              clk,
    input  wire logic              nrst,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output logic [1:0]             s_axi_bresp,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    input  wire logic              osc_tick,
    input  wire logic              alarm0_match,
    input  wire logic              alarm1_match,
    input  wire logic              on_backup,
    input  wire logic              square_wave_in,
    output logic                   multi_function_pin_o,
    output logic                   multi_function_pin_oe_n,
    output logic                   trimmed_tick,
    output logic                   second_tick
);

    // Decoder looks at the low eight address bits
    if (ADDR_W < 8 || ADDR_W > 32)
    begin : g_bad_addr_w
        $error("rtc_mfp_core: bad ADDR_W");
    end

    typedef struct packed {
        logic        awh;
        logic [ADDR_W-1:0] awa;
        logic        wh;
        logic [31:0] wd;
        logic [3:0]  ws;
        logic        bv;
        logic [1:0]  br;
        logic        rv;
        logic [31:0] rd;
        logic [1:0]  rr;
        logic [7:0]  ctrl;
        logic [7:0]  trim;
        logic [7:0]  a0cfg;
        logic [7:0]  a1cfg;
        logic        a0f;
        logic        a1f;
        logic [14:0] pre;
        logic [5:0]  sec;
        logic        tt;
        logic        st;
        logic        pin;
        logic        oe_n;
    } core_s;

    core_s r_q;
    core_s r_d;

    logic adding;
    logic removing;
    logic trim_start;
    logic trim_at;
    logic pre_wrap;

    // ==========================================================
    // Trim point: fixed place in the prescaler, away from wrap
    assign trim_at = r_q.ctrl[`CTRL_CRS_BIT]
        ? ((r_q.pre & `COARSE_MASK) == `COARSE_POINT)                            // R12
        : (r_q.pre == `FINE_POINT && r_q.sec == `SECS_PER_MIN);                  // R8 R21
    assign trim_start = osc_tick && trim_at && !adding && !removing;
    assign pre_wrap   = (r_q.pre == `TICKS_PER_SEC);

    trim_step #(.MAG_W(7)) trim_step_i
    (
        .clk       (clk),
        .nrst      (nrst),
        .start     (trim_start),
        .add       (r_q.trim[`TRIM_SIGN_BIT]),
        .magnitude (r_q.trim[6:0]),
        .tick      (osc_tick),
        .adding    (adding),
        .removing  (removing)
    );

    // ==========================================================
    // Next state
    always_comb
    begin
        logic       we;
        logic [7:0] wb;
        logic       one;
        logic       both;
        logic       sel;
        pin_mode_e  mode;
        logic       adv;
        logic       extra;
        we    = 1'b0;
        wb    = 8'h00;
        one   = 1'b0;
        both  = 1'b0;
        sel   = 1'b0;
        mode  = PIN_GPIO;
        adv   = 1'b0;
        extra = 1'b0;
        r_d   = r_q;
        r_d.tt = 1'b0;
        r_d.st = 1'b0;

        // Write channel: address and data in either order
        if (s_axi_awvalid && !r_q.awh)
        begin
            r_d.awh = 1'b1;
            r_d.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r_q.wh)
        begin
            r_d.wh = 1'b1;
            r_d.wd = s_axi_wdata;
            r_d.ws = s_axi_wstrb;
        end
        if (r_q.awh && r_q.wh && !r_q.bv)
        begin
            we      = r_q.ws[0];
            wb      = r_q.wd[7:0];
            r_d.awh = 1'b0;
            r_d.wh  = 1'b0;
            r_d.bv  = 1'b1;
            r_d.br  = 2'b00;
            case (r_q.awa[7:0])
                `CTRL_OFS:     if (we) r_d.ctrl = wb;
                `TRIM_OFS:     if (we) r_d.trim = wb;
                `ALM0_CFG_OFS: if (we) r_d.a0cfg = wb;
                `ALM1_CFG_OFS: if (we) r_d.a1cfg = wb;
                `STATUS_OFS, `TICKS_OFS: r_d.br = 2'b00;
                default:       r_d.br = 2'b10;
            endcase
            // Polarity is one bit shared by both alarm registers
            if (we && (r_q.awa[7:0] == `ALM0_CFG_OFS || r_q.awa[7:0] == `ALM1_CFG_OFS))
            begin
                r_d.a0cfg[`ACFG_POL_BIT] = wb[`ACFG_POL_BIT];
                r_d.a1cfg[`ACFG_POL_BIT] = wb[`ACFG_POL_BIT];
            end
        end
        if (r_q.bv && s_axi_bready)
            r_d.bv = 1'b0;

        // Read channel
        if (s_axi_arvalid && !r_q.rv)
        begin
            r_d.rv = 1'b1;
            r_d.rr = 2'b00;
            case (s_axi_araddr[7:0])
                `CTRL_OFS:     r_d.rd = {24'h000000, r_q.ctrl};
                `TRIM_OFS:     r_d.rd = {24'h000000, r_q.trim};
                `ALM0_CFG_OFS: r_d.rd = {24'h000000, r_q.a0cfg[7:4], r_q.a0f, r_q.a0cfg[2:0]};
                `ALM1_CFG_OFS: r_d.rd = {24'h000000, r_q.a1cfg[7:4], r_q.a1f, r_q.a1cfg[2:0]};
                `STATUS_OFS:   r_d.rd = {29'h00000000, adding, removing, r_q.pin};
                `TICKS_OFS:    r_d.rd = {11'h000, r_q.sec, r_q.pre};
                default:
                begin
                    r_d.rd = 32'h00000000;
                    r_d.rr = 2'b10;
                end
            endcase
        end
        if (r_q.rv && s_axi_rready)
            r_d.rv = 1'b0;

        // Sticky flags: any write to its config with byte 0 strobed clears, a match sets and wins
        if (we && r_q.awa[7:0] == `ALM0_CFG_OFS && r_q.awh && r_q.wh && !r_q.bv)
            r_d.a0f = 1'b0;
        if (we && r_q.awa[7:0] == `ALM1_CFG_OFS && r_q.awh && r_q.wh && !r_q.bv)
            r_d.a1f = 1'b0;
        if (alarm0_match)
            r_d.a0f = 1'b1;                                                      // R19
        if (alarm1_match)
            r_d.a1f = 1'b1;                                                      // R19

        // Prescaler: suppressed ticks hold it, inserted ticks add a count
        adv   = osc_tick && !removing;                                           // R9 R21
        extra = osc_tick && adding;                                              // R9 R21
        if (adv)
        begin
            r_d.tt = 1'b1;
            // Inserted count at the wrap still lands, no trim step lost
            if (pre_wrap || (extra && r_q.pre == `TICKS_PER_SEC - 15'h0001))
            begin
                r_d.pre = (extra && pre_wrap) ? 15'h0001 : 15'h0000;
                r_d.st  = 1'b1;
                r_d.sec = (r_q.sec == `SECS_PER_MIN) ? 6'h00 : r_q.sec + 6'h01;
            end
            else if (extra)
                r_d.pre = r_q.pre + 15'h0002;
            else
                r_d.pre = r_q.pre + 15'h0001;
        end
        // Trimming above has no dependence on on_backup.                       // R13

        // Pin mode selection
        if (r_q.ctrl[`CTRL_SQUARE_WAVE_ENABLE_BIT])
            mode = PIN_SQUARE;                                                   // R18
        else if (r_q.ctrl[`CTRL_A0EN_BIT] || r_q.ctrl[`CTRL_A1EN_BIT])
            mode = PIN_ALARM;                                                    // R1 R18
        else
            mode = PIN_GPIO;                                                     // R6 R18

        one  = r_q.ctrl[`CTRL_A0EN_BIT] ? r_q.a0f : r_q.a1f;
        both = r_q.a0cfg[`ACFG_POL_BIT] ? (r_q.a0f | r_q.a1f)                    // R4
                                        : ~(r_q.a0f & r_q.a1f);                  // R5
        case (mode)
            PIN_ALARM:
            begin
                if (r_q.ctrl[`CTRL_A0EN_BIT] && r_q.ctrl[`CTRL_A1EN_BIT])
                    sel = both;
                else
                    sel = r_q.a0cfg[`ACFG_POL_BIT] ? one : ~one;                 // R3
                r_d.pin  = sel;
                r_d.oe_n = sel;                                                  // R2
            end
            PIN_SQUARE:
            begin
                // Coarse 64 Hz comes from the trimmed prescaler
                sel = r_q.ctrl[`CTRL_CRS_BIT] ? r_q.pre[8] : square_wave_in;     // R20
                r_d.pin  = sel;
                r_d.oe_n = sel | on_backup;
            end
            PIN_GPIO:
            begin
                sel = r_q.ctrl[`CTRL_OUT_BIT];                                   // R6
                r_d.pin  = sel;
                r_d.oe_n = sel | on_backup;                                      // R7
            end
            default:
            begin
                r_d.pin  = 1'b1;
                r_d.oe_n = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            r_q       <= '0;
            r_q.ctrl  <= `CTRL_RST;
            r_q.trim  <= `TRIM_RST;
            r_q.a0cfg <= `ACFG_RST;
            r_q.a1cfg <= `ACFG_RST;
            r_q.pin   <= 1'b1;
            r_q.oe_n  <= 1'b1;
        end
        else
            r_q <= r_d;
    end

    // ==========================================================
    // Outputs
    assign s_axi_awready           = !r_q.awh;
    assign s_axi_wready            = !r_q.wh;
    assign s_axi_bvalid            = r_q.bv;
    assign s_axi_bresp             = r_q.br;
    assign s_axi_arready           = !r_q.rv;
    assign s_axi_rvalid            = r_q.rv;
    assign s_axi_rdata             = r_q.rd;
    assign s_axi_rresp             = r_q.rr;
    assign multi_function_pin_o    = r_q.pin;
    assign multi_function_pin_oe_n = r_q.oe_n;
    assign trimmed_tick            = r_q.tt;
    assign second_tick             = r_q.st;

endmodule : rtc_mfp_core

// file: src/rtc_mfp_map.svh
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: 32-bit AXI4-Lite word per register, byte addresses
// Notes:   Definitions only
`ifndef RTC_MFP_MAP_SVH
`define RTC_MFP_MAP_SVH

// ==========================================================
// Offsets
`define CTRL_OFS        8'h00
`define TRIM_OFS        8'h08
`define ALM0_CFG_OFS    8'h0c
`define ALM1_CFG_OFS    8'h10
`define STATUS_OFS      8'h14
`define TICKS_OFS       8'h18

// ==========================================================
// Control fields
`define CTRL_OUT_BIT    7
`define CTRL_SQUARE_WAVE_ENABLE_BIT  6
`define CTRL_A1EN_BIT   5
`define CTRL_A0EN_BIT   4
`define CTRL_EXTERNAL_CLOCK_INPUT_ENABLE_BIT 3
`define CTRL_CRS_BIT    2
`define CTRL_RST        8'h80

// ==========================================================
// Trim and alarm config fields
`define TRIM_SIGN_BIT   7
`define TRIM_RST        8'h00
`define ACFG_POL_BIT    7
`define ACFG_FLAG_BIT   3
`define ACFG_RST        8'h00

// ==========================================================
// Timebase: 32768 ticks per second, 60 s per minute, 256 ticks per coarse step
`define TICKS_PER_SEC   15'h7fff
`define SECS_PER_MIN    6'h3b
`define COARSE_MASK     15'h00ff
`define COARSE_POINT    15'h0080
`define FINE_POINT      15'h4000

`endif

// file: src/rtc_mfp_pkg.sv
// Purpose: Types shared by the output and trim logic
// Assumes: Nothing
// Notes:   Constants live in rtc_mfp_map.svh
package rtc_mfp_pkg;

    typedef enum logic [1:0]
    {
        PIN_GPIO   = 2'b00,
        PIN_ALARM  = 2'b01,
        PIN_SQUARE = 2'b10
    } pin_mode_e;

    typedef enum logic [1:0]
    {
        TRIM_IDLE = 2'b00,
        TRIM_ADD  = 2'b01,
        TRIM_SUB  = 2'b10
    } trim_state_e;

endpackage : rtc_mfp_pkg

// file: src/trim_step.sv
// Purpose: Counts out one trim adjustment, one tick per enable
// Assumes: Start only while idle
// Notes:   Busy stays high for twice the magnitude in ticks
`timescale 1ns/100ps
module trim_step
    import rtc_mfp_pkg::*;
#(
    parameter int MAG_W = 7
)
(
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             start,
    input  wire logic             add,
    input  wire logic [MAG_W-1:0] magnitude,
    input  wire logic             tick,
    output logic                  adding,
    output logic                  removing
);

    if (MAG_W < 1 || MAG_W > 15)
    begin : g_bad_mag_w
        $error("trim_step: bad MAG_W");
    end

    typedef struct packed {
        trim_state_e      st;
        logic [MAG_W:0]   left;
    } step_s;

    step_s r_q;
    step_s r_d;

    // ==========================================================
    // Next state
    always_comb
    begin
        r_d = r_q;
        case (r_q.st)
            TRIM_IDLE:
            begin
                if (start && magnitude != '0)                                    // R11
                begin
                    r_d.st   = add ? TRIM_ADD : TRIM_SUB;                        // R9
                    r_d.left = {magnitude, 1'b0};                                // R10
                end
            end
            TRIM_ADD, TRIM_SUB:
            begin
                if (tick)
                begin
                    r_d.left = r_q.left - 1'b1;
                    if (r_q.left == 1)
                        r_d.st = TRIM_IDLE;
                end
            end
            default: r_d.st = TRIM_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            r_q <= '{st: TRIM_IDLE, left: '0};
        else
            r_q <= r_d;
    end

    assign adding   = (r_q.st == TRIM_ADD);
    assign removing = (r_q.st == TRIM_SUB);

endmodule : trim_step

// file: tb/rtc_mfp_checker.sv
// Purpose: Port assertions for pin mux, trim tick and register bus
// Assumes: Write address and data offered together
// Notes:   Control shadow tracks writes to control
`timescale 1ns/100ps
`include "rtc_mfp_map.svh"
module rtc_mfp_checker
#(
    parameter int ADDR_W = 8
)
(
    input wire logic              clk,
    input wire logic              nrst,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic [31:0]       s_axi_wdata,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_rvalid,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              osc_tick,
    input wire logic              on_backup,
    input wire logic              square_wave_in,
    input wire logic              multi_function_pin_o,
    input wire logic              multi_function_pin_oe_n,
    input wire logic              trimmed_tick
);
    // ==========================================
    // Control shadow
    logic [7:0] ctrl_q;
    logic       gp;
    logic       sq;
    // Split address and data are not tracked
    always_ff @(posedge clk)
    begin
        if (!nrst)
            ctrl_q <= `CTRL_RST;
        else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == `CTRL_OFS)
            ctrl_q <= s_axi_wdata[7:0];
    end
    assign gp = ctrl_q[6:4] == 3'h0;
    assign sq = ctrl_q[6];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    // ==========================================
    // Assertions
    AST_OPEN_DRAIN: assert property (!$past(on_backup) |-> multi_function_pin_oe_n == multi_function_pin_o)
        else $error("pin enable and level differ");
    AST_GPIO_LEVEL: assert property ((gp && !on_backup && $stable(ctrl_q)) [*4] |-> multi_function_pin_o == ctrl_q[7])
        else $error("general output level wrong");
    AST_GPIO_OFF: assert property ((gp && on_backup && $stable(ctrl_q)) [*3] |-> multi_function_pin_oe_n)
        else $error("general output driven on backup");
    AST_SQ_FOLLOW: assert property ((sq && !ctrl_q[2] && !on_backup && $stable(ctrl_q)) [*4]
        |-> multi_function_pin_o == $past(square_wave_in)) else $error("square wave not on pin");
    AST_SQ_OFF: assert property ((sq && on_backup && $stable(ctrl_q)) [*3] |-> multi_function_pin_oe_n)
        else $error("square wave driven on backup");
    AST_WR_RESP: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    AST_RD_RESP: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
        else $error("read response late");
    AST_RD_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
    AST_TRIM_PULSE: assert property (trimmed_tick |-> $past(osc_tick))
        else $error("prescaler advanced without oscillator tick");
    cover property (gp && on_backup);
    cover property (sq && $rose(multi_function_pin_o));
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : rtc_mfp_checker

bind rtc_mfp_core rtc_mfp_checker #(.ADDR_W(ADDR_W)) rtc_mfp_checker_i (.*);

// file: tb/mfp_host_model.sv
// Purpose: Host side of the open-drain multi-function pin
// Assumes: Pull-up on the line
// Notes:   Device can only pull low
`timescale 1ns/100ps
module mfp_host_model
(
    input  wire logic multi_function_pin_oe_n,
    output logic      pin_line
);
    // Pull-up wins whenever the device lets go
    assign pin_line = multi_function_pin_oe_n ? 1'h1 : 1'h0;
endmodule : mfp_host_model

// file: tb/rtc_mfp_core_tb.sv
// Purpose: Self-checking bench for pin mux and trim
// Assumes: Bench drives the oscillator tick
// Notes:   Fine trim needs a full minute, not run
`timescale 1ns/100ps
`include "rtc_mfp_map.svh"
module rtc_mfp_core_tb;
    logic        clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, osc_tick, alarm0_match, alarm1_match;
    logic        on_backup, square_wave_in, multi_function_pin_o, multi_function_pin_oe_n, trimmed_tick, second_tick;
    logic        pin_line;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    int          n_errors = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          n_sec = 0;

    rtc_mfp_core   rtc_mfp_core_i (.*);
    mfp_host_model mfp_host_model_i (.multi_function_pin_oe_n(multi_function_pin_oe_n), .pin_line(pin_line));

    // ==========================================
    // Clock and timeout
    initial
    begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        if (second_tick === 1'h1)
            n_sec++;
        cyc++;
        if (cyc == 80000)
        begin
            n_errors++;
            stop_test();
        end
    end

    // ==========================================
    // Shared tasks
    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk_pin(input string what, input logic exp);
        repeat (3) @(posedge clk);
        checks_done++;
        if (pin_line !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, pin_line);
        end
    endtask : chk_pin
    task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid  <= 1'h1;
        s_axi_bready  <= 1'h1;
        do
        begin
            @(posedge clk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'h0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'h0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
        @(posedge clk);
    endtask : axw
    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready  <= 1'h1;
        do
        begin
            @(posedge clk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'h0;
        end
        while (!s_axi_rvalid);
        s_axi_rready <= 1'h0;
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        @(posedge clk);
    endtask : axr
    task automatic ticks(input int n);
        repeat (n)
        begin
            osc_tick <= 1'h1;
            @(posedge clk);
            osc_tick <= 1'h0;
            @(posedge clk);
        end
    endtask : ticks

    // ==========================================
    // Scenarios
    task automatic t_reset();
        axr(`CTRL_OFS, 32'h80, 2'h0);
        axr(`TRIM_OFS, 32'h0, 2'h0);
        axr(`ALM0_CFG_OFS, 32'h0, 2'h0);
        axr(8'h1c, 32'h0, 2'h2);
        axw(8'h1c, 8'h5a, 2'h2);
        axw(`TRIM_OFS, 8'ha5, 2'h0);
        axr(`TRIM_OFS, 32'ha5, 2'h0);
        chk_pin("gpio reset", 1'h1);
    endtask : t_reset
    task automatic t_gpio();
        axw(`CTRL_OFS, 8'h00, 2'h0);
        chk_pin("gpio low", 1'h0);
        on_backup <= 1'h1;
        chk_pin("gpio backup", 1'h1);
        on_backup <= 1'h0;
        chk_pin("gpio again", 1'h0);
    endtask : t_gpio
    task automatic t_alarm();
        logic [1:0] en;
        logic       pol;
        logic [1:0] f;
        logic       exp;
        for (int i = 0; i < 24; i++)
        begin
            en = 2'(i % 3 + 1);
            pol = 1'(i / 3 % 2);
            f = 2'(i / 6);
            axw(`CTRL_OFS, {2'h0, en, 4'h0}, 2'h0);
            axw(`ALM0_CFG_OFS, {pol, 7'h0}, 2'h0);
            axw(`ALM1_CFG_OFS, {pol, 7'h0}, 2'h0);
            on_backup <= i[0];
            alarm0_match <= f[0];
            alarm1_match <= f[1];
            @(posedge clk);
            alarm0_match <= 1'h0;
            alarm1_match <= 1'h0;
            exp = (en == 2'h3) ? (pol ? |f : !(&f)) : ((en[0] ? f[0] : f[1]) ~^ pol);
            chk_pin("alarm pin", exp);
            on_backup <= 1'h0;
            axr(`ALM0_CFG_OFS, {24'h0, pol, 3'h0, f[0], 3'h0}, 2'h0);
        end
        // Match still present when cleared
        alarm0_match <= 1'h1;
        axw(`ALM0_CFG_OFS, 8'h00, 2'h0);
        axr(`ALM0_CFG_OFS, 32'h08, 2'h0);
        alarm0_match <= 1'h0;
        axw(`ALM0_CFG_OFS, 8'h00, 2'h0);
        axr(`ALM0_CFG_OFS, 32'h00, 2'h0);
    endtask : t_alarm
    task automatic t_square();
        axw(`CTRL_OFS, 8'h70, 2'h0);
        for (int i = 0; i < 4; i++)
        begin
            square_wave_in <= i[0];
            chk_pin("square", i[0]);
        end
        on_backup <= 1'h1;
        square_wave_in <= 1'h0;
        chk_pin("square backup", 1'h1);
        on_backup <= 1'h0;
    endtask : t_square
    task automatic t_trim();
        logic [14:0] pre;
        logic [7:0]  tv [4] = '{8'h81, 8'h02, 8'h80, 8'h83};
        real         ppm;
        int          mag;
        pre = 15'h0;
        axw(`TRIM_OFS, 8'h00, 2'h0);
        axw(`CTRL_OFS, 8'h04, 2'h0);
        // Windows start clear of the trim point, two points each
        for (int k = 0; k < 4; k++)
        begin
            axw(`TRIM_OFS, tv[k], 2'h0);
            on_backup <= (k == 1);
            ticks(512);
            on_backup <= 1'h0;
            pre = tv[k][7] ? pre + 15'h200 + {6'h0, tv[k][6:0], 2'h0} : pre + 15'h200 - {6'h0, tv[k][6:0], 2'h0};
            axr(`TICKS_OFS, {17'h0, pre}, 2'h0);
        end
        // Host math: slow 1 Hz output measured, then 1 s gained in 100000 s
        mag = int'((1.0 - 0.9999) * 32768.0 / 1.0 * 60.0 / 2.0);
        axw(`TRIM_OFS, {1'h1, 7'(mag)}, 2'h0);
        axr(`TRIM_OFS, 32'he2, 2'h0);
        ppm = 1.0 / 100000.0 * 1000000.0;
        mag = int'(ppm * 32768.0 * 60.0 / 2000000.0);
        axw(`TRIM_OFS, {1'h0, 7'(mag)}, 2'h0);
        axr(`TRIM_OFS, 32'h0a, 2'h0);
        axw(`TRIM_OFS, 8'h00, 2'h0);
        axw(`CTRL_OFS, 8'h44, 2'h0);
        chk_pin("coarse square", pre[8]);
        ticks(256);
        chk_pin("coarse square", ~pre[8]);
        // Run on to the first prescaler wrap, trim off
        ticks(30456);
        axr(`TICKS_OFS, 32'h00008000, 2'h0);
        chk("second ticks", 32'h1, n_sec);
    endtask : t_trim

    // ==========================================
    // Main sequence
    initial
    begin
        nrst = 1'h0;
        s_axi_awvalid = 1'h0;
        s_axi_wvalid = 1'h0;
        s_axi_bready = 1'h0;
        s_axi_arvalid = 1'h0;
        s_axi_rready = 1'h0;
        s_axi_awaddr = 8'h0;
        s_axi_araddr = 8'h0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        osc_tick = 1'h0;
        alarm0_match = 1'h0;
        alarm1_match = 1'h0;
        on_backup = 1'h0;
        square_wave_in = 1'h0;
        repeat (8) @(posedge clk);
        nrst <= 1'h1;
        @(posedge clk);
        t_reset();
        t_gpio();
        t_alarm();
        t_square();
        t_trim();
        stop_test();
    end
endmodule : rtc_mfp_core_tb
